/* pwm_output_pin_control.sv */
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
module pwm_output_pin_control
	import pwm_pin_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Generator side
	input  wire logic              gen_high_wave,
	input  wire logic              gen_low_wave,
	input  wire logic              gen_period_start,
	// GPIO side
	input  wire logic              gpio_high_level,
	input  wire logic              gpio_low_level,
	// Fault pin, asynchronous
	input  wire logic              fault_in,
	// Pins and ownership
	output logic                   high_side_out_pin,
	output logic                   low_side_out_pin,
	output logic                   high_pin_owner_sel,
	output logic                   low_pin_owner_sel
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [15:0]       out_ctrl_q;
	logic [1:0]        fault_sel_q;
	logic              fault_latched_q;
	logic              pp_phase_q;

	logic              aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_held_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	logic              do_write;
	logic [2:0]        wr_sel;
	logic [2:0]        rd_sel;
	logic [31:0]       rd_word;
	logic              fault_sync;
	logic              fault_force;
	logic              wave_hi;
	logic              wave_lo;
	pair_mode_t        mode;
	fault_sel_t        fsel;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// One-hot: bit 0 control, bit 1 fault control, bit 2 status;
	// all zero means unmapped. Shared by write and read paths.
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [2:0] s;
		s = 3'h0;
		if (a == OUT_CTRL_OFFSET) begin
			s = 3'h1;
		end else if (a == FAULT_CTRL_OFFSET) begin
			s = 3'h2;
		end else if (a == STATUS_OFFSET) begin
			s = 3'h4;
		end else begin
			s = 3'h0;
		end
		return s;
	endfunction : reg_sel

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction : merge16

	// ------------------------------------------------------------
	// Write channel handshakes
	// ------------------------------------------------------------
	// Address and data are caught independently, in either order;
	// nothing new is taken while a response waits
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign do_write      = aw_held_q && w_held_q && !bvalid_q;
	assign wr_sel        = reg_sel(aw_addr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	// Response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Unimplemented bits are masked off on write so they always
	// read back as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_ctrl_q <= OUT_CTRL_RESET;
		end else if (do_write && wr_sel[0]) begin
			out_ctrl_q <= merge16(out_ctrl_q, w_data_q, w_strb_q)
				& OUT_CTRL_IMPL_MASK;
		end
	end

	// Fault response defaults to disabled so reset never forces pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_sel_q <= FAULT_CTRL_RESET;
		end else if (do_write && wr_sel[1] && w_strb_q[0]) begin
			fault_sel_q <= w_data_q[1:0];
		end
	end

	// ------------------------------------------------------------
	// Fault input and latch
	// ------------------------------------------------------------
	level_sync u_fault_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (fault_in),
		.sync_out (fault_sync)
	);

	assign fsel = fault_sel_t'(fault_sel_q);

	// Latched fault is cleared by writing one to its status bit;
	// a fault present in the same cycle with latched response selected keeps it set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_latched_q <= 1'b0;
		end else if (fault_sync && fsel == FAULT_LATCHED) begin
			fault_latched_q <= 1'b1;
		end else if (do_write && wr_sel[2] && w_strb_q[0]
				&& w_data_q[STAT_FAULT_LAT_BIT]) begin
			fault_latched_q <= 1'b0;
		end
	end

	// Cycle-by-cycle follows the pin; latched also holds after it
	always_comb begin
		case (fsel)
			FAULT_LATCHED:  fault_force = fault_sync || fault_latched_q;
			FAULT_CYCLE:    fault_force = fault_sync;
			FAULT_CYCLE_B:  fault_force = fault_sync;
			FAULT_DISABLED: fault_force = 1'b0;
			default:        fault_force = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Pin-pair mode
	// ------------------------------------------------------------
	assign mode = pair_mode_t'(out_ctrl_q[MODE_HI_BIT:MODE_LO_BIT]);

	// Push-pull phase flips on each period start; held at zero in
	// other modes so push-pull always begins on the high pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pp_phase_q <= 1'b0;
		end else if (mode != MODE_PUSH_PULL) begin
			pp_phase_q <= 1'b0;
		end else if (gen_period_start) begin
			pp_phase_q <= !pp_phase_q;
		end
	end

	// Route the generator waveform according to the mode
	always_comb begin
		case (mode)
			MODE_COMPLEMENTARY: begin
				wave_hi = gen_high_wave;
				wave_lo = !gen_high_wave;
			end
			MODE_REDUNDANT: begin
				wave_hi = gen_high_wave;
				wave_lo = gen_high_wave;
			end
			MODE_PUSH_PULL: begin
				wave_hi = gen_high_wave && !pp_phase_q;
				wave_lo = gen_high_wave && pp_phase_q;
			end
			MODE_INDEPENDENT: begin
				wave_hi = gen_high_wave;
				wave_lo = gen_low_wave;
			end
			default: begin
				wave_hi = gen_high_wave;
				wave_lo = !gen_high_wave;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Output stages
	// ------------------------------------------------------------
	pin_stage u_high_stage (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.pwm_owner      (out_ctrl_q[HIGH_OWNER_BIT]),
		.invert         (out_ctrl_q[HIGH_INVERT_BIT]),
		.override_en    (out_ctrl_q[HIGH_OVR_EN_BIT]),
		.override_level (out_ctrl_q[OVR_DATA_HI_BIT]),
		.fault_force    (fault_force),
		.fault_level    (out_ctrl_q[FAULT_LEVEL_HI_BIT]),
		.wave           (wave_hi),
		.gpio_level     (gpio_high_level),
		.pin_q          (high_side_out_pin)
	);

	pin_stage u_low_stage (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.pwm_owner      (out_ctrl_q[LOW_OWNER_BIT]),
		.invert         (out_ctrl_q[LOW_INVERT_BIT]),
		.override_en    (out_ctrl_q[LOW_OVR_EN_BIT]),
		.override_level (out_ctrl_q[OVR_DATA_LO_BIT]),
		.fault_force    (fault_force),
		.fault_level    (out_ctrl_q[FAULT_LEVEL_LO_BIT]),
		.wave           (wave_lo),
		.gpio_level     (gpio_low_level),
		.pin_q          (low_side_out_pin)
	);

	// Ownership told to the pad mux straight from the register
	assign high_pin_owner_sel = out_ctrl_q[HIGH_OWNER_BIT];
	assign low_pin_owner_sel  = out_ctrl_q[LOW_OWNER_BIT];

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign rd_sel        = reg_sel(s_axi_araddr);
	assign s_axi_arready = !rvalid_q;

	// Read word assembly; bits above each field read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (rd_sel[0]) begin
			rd_word[15:0] = out_ctrl_q;
		end else if (rd_sel[1]) begin
			rd_word[1:0] = fault_sel_q;
		end else if (rd_sel[2]) begin
			rd_word[STAT_HIGH_PIN_BIT]  = high_side_out_pin;
			rd_word[STAT_LOW_PIN_BIT]   = low_side_out_pin;
			rd_word[STAT_FAULT_IN_BIT]  = fault_sync;
			rd_word[STAT_FAULT_LAT_BIT] = fault_latched_q;
			rd_word[STAT_PP_PHASE_BIT]  = pp_phase_q;
		end
	end

	// Data captured at the address handshake and held until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= (rd_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

endmodule : pwm_output_pin_control

/* pwm_pin_pkg.sv */
package pwm_pin_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  OUT_CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  FAULT_CTRL_OFFSET = 8'h04;
	localparam logic [7:0]  STATUS_OFFSET     = 8'h08;

	// ------------------------------------------------------------
	// Output control field positions
	// ------------------------------------------------------------
	localparam int HIGH_OWNER_BIT    = 15;
	localparam int LOW_OWNER_BIT     = 14;
	localparam int HIGH_INVERT_BIT   = 13;
	localparam int LOW_INVERT_BIT    = 12;
	localparam int MODE_HI_BIT       = 11;
	localparam int MODE_LO_BIT       = 10;
	localparam int LOW_OVR_EN_BIT    = 9;
	localparam int HIGH_OVR_EN_BIT   = 8;
	localparam int OVR_DATA_HI_BIT   = 7;
	localparam int OVR_DATA_LO_BIT   = 6;
	localparam int FAULT_LEVEL_HI_BIT = 5;
	localparam int FAULT_LEVEL_LO_BIT = 4;
	localparam logic [15:0] OUT_CTRL_IMPL_MASK = 16'hFFF0;
	localparam logic [15:0] OUT_CTRL_RESET     = 16'h0000;

	// ------------------------------------------------------------
	// Fault control and status fields
	// ------------------------------------------------------------
	localparam logic [1:0] FAULT_CTRL_RESET = 2'h3;
	localparam int STAT_HIGH_PIN_BIT  = 0;
	localparam int STAT_LOW_PIN_BIT   = 1;
	localparam int STAT_FAULT_IN_BIT  = 2;
	localparam int STAT_FAULT_LAT_BIT = 3;
	localparam int STAT_PP_PHASE_BIT  = 4;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_COMPLEMENTARY = 2'h0,
		MODE_REDUNDANT     = 2'h1,
		MODE_PUSH_PULL     = 2'h2,
		MODE_INDEPENDENT   = 2'h3
	} pair_mode_t;

	typedef enum logic [1:0] {
		FAULT_LATCHED  = 2'h0,
		FAULT_CYCLE    = 2'h1,
		FAULT_CYCLE_B  = 2'h2,
		FAULT_DISABLED = 2'h3
	} fault_sel_t;

endpackage : pwm_pin_pkg

/* level_sync.sv */
module level_sync
	import pwm_pin_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_q;

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	// First stage is read only by the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : level_sync

/* pin_stage.sv */
module pin_stage
	import pwm_pin_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pwm_owner,
	input  wire logic invert,
	input  wire logic override_en,
	input  wire logic override_level,
	input  wire logic fault_force,
	input  wire logic fault_level,
	input  wire logic wave,
	input  wire logic gpio_level,
	output logic      pin_q
);

	logic active_lvl;
	logic pin_d;

	// ------------------------------------------------------------
	// Source priority: GPIO ownership, then fault, then override, then generator
	// ------------------------------------------------------------
	// Polarity acts last so override and fault data name the
	// asserted state, not the raw pin level
	always_comb begin
		if (fault_force) begin
			active_lvl = fault_level;
		end else if (override_en) begin
			active_lvl = override_level;
		end else begin
			active_lvl = wave;
		end
		if (pwm_owner) begin
			pin_d = active_lvl ^ invert;
		end else begin
			pin_d = gpio_level;
		end
	end

	// Registered pin so glitches of the mux never reach the driver
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

endmodule : pin_stage

/* gate_driver_model.sv */
// ------------------------------------------------------------
// Power-stage gate driver pair seen from the pins
// ------------------------------------------------------------
module gate_driver_model (
	input  wire logic aclk,
	input  wire logic hi_gate,
	input  wire logic lo_gate,
	output logic [15:0] overlap_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] cnt = 16'h0000;

	// Counts cycles with both switches on; a real stage would short here
	always @(posedge aclk) begin
		if ((hi_gate === 1'b1) && (lo_gate === 1'b1)) begin
			cnt <= cnt + 16'h0001;
		end
	end
	assign overlap_cnt = cnt;
endmodule : gate_driver_model

/* pwm_pin_assertions.sv */
// ------------------------------------------------------------
// Port checker for the output pin control
// ------------------------------------------------------------
module pwm_pin_checker
	import pwm_pin_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              gpio_high_level,
	input wire logic              gpio_low_level,
	input wire logic              high_side_out_pin,
	input wire logic              low_side_out_pin,
	input wire logic              high_pin_owner_sel,
	input wire logic              low_pin_owner_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Unmapped reads: any address other than the three register offsets
	logic ar_bad;
	assign ar_bad = (s_axi_araddr != OUT_CTRL_OFFSET)
		&& (s_axi_araddr != FAULT_CTRL_OFFSET)
		&& (s_axi_araddr != STATUS_OFFSET);

	a_gpio_high_pin: assert property (
		!high_pin_owner_sel |=> high_side_out_pin == $past(gpio_high_level))
		else $error("high pin not following gpio level");
	a_gpio_low_pin: assert property (
		!low_pin_owner_sel |=> low_side_out_pin == $past(gpio_low_level))
		else $error("low pin not following gpio level");
	a_read_answer_next: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_unmapped_err: assert property (
		s_axi_arvalid && s_axi_arready && ar_bad
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_rdata_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_bresp_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_arready_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_awready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	a_rvalid_drops: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated after it was taken");
	a_bvalid_drops: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated after it was taken");
	a_ctrl_unimpl_zero: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == OUT_CTRL_OFFSET
		|=> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:16] == 16'h0000)
		else $error("unimplemented control bits read nonzero");

	c_gen_owns: cover property (high_pin_owner_sel && low_pin_owner_sel);
	c_bad_read: cover property (s_axi_arvalid && s_axi_arready && ar_bad);
	c_write_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : pwm_pin_checker

bind pwm_output_pin_control pwm_pin_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_awready(s_axi_awready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.gpio_high_level(gpio_high_level), .gpio_low_level(gpio_low_level),
	.high_side_out_pin(high_side_out_pin),
	.low_side_out_pin(low_side_out_pin),
	.high_pin_owner_sel(high_pin_owner_sel),
	.low_pin_owner_sel(low_pin_owner_sel));

/* pwm_output_pin_control_bench.sv */
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module pwm_output_pin_control_bench;
	import pwm_pin_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, wa, wb, pstart, g_hi, g_lo;
	logic flt, hi, lo, own_hi, own_lo;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [15:0] overlap;
	int errors, n_tests, m;

	pwm_output_pin_control DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .gen_high_wave(wa), .gen_low_wave(wb),
		.gen_period_start(pstart), .gpio_high_level(g_hi),
		.gpio_low_level(g_lo), .fault_in(flt), .high_side_out_pin(hi),
		.low_side_out_pin(lo), .high_pin_owner_sel(own_hi),
		.low_pin_owner_sel(own_lo));
	gate_driver_model u_gate (.aclk(aclk), .hi_gate(hi), .lo_gate(lo),
		.overlap_cnt(overlap));

	// ------------------------------------------------------------
	// Clock, closing report
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task final_report();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Bus master tasks; every wait is bounded
	// ------------------------------------------------------------
	task axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int i;
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		// One idle edge so a following call never re-raises bready
		@(posedge aclk);
		if (i == 60) begin errors++; final_report(); end
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int i;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata; r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (i == 60) begin errors++; final_report(); end
	endtask : axr
	// Pins are one flop behind their causes; fault path needs three
	task pins(input logic eh, input logic el);
		repeat (5) @(posedge aclk);
		`CHK(hi, eh)
		`CHK(lo, el)
	endtask : pins

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		errors = 0; n_tests = 0; aresetn = 1'b0; awvalid = 1'b0;
		wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wa = 1'b0;
		wb = 1'b0; pstart = 1'b0; g_hi = 1'b0; g_lo = 1'b0; flt = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(OUT_CTRL_OFFSET, rd, rs); `CHK(rd, 32'h0)
		axr(FAULT_CTRL_OFFSET, rd, rs); `CHK(rd[1:0], FAULT_CTRL_RESET)
		`CHK({own_hi, own_lo}, 2'b00)
		axw(OUT_CTRL_OFFSET, 32'hFFFF_FFFF, rs); `CHK(rs, RESP_OKAY)
		axr(OUT_CTRL_OFFSET, rd, rs); `CHK(rd, 32'h0000_FFF0)
		axw(8'h0C, 32'h1, rs); `CHK(rs, RESP_SLVERR)
		axr(8'h0C, rd, rs); `CHK(rs, RESP_SLVERR)
		// GPIO owns both, then generator takes only the high pin
		g_hi <= 1'b1; wa <= 1'b0;
		axw(OUT_CTRL_OFFSET, 32'h0, rs); pins(1'b1, 1'b0);
		axw(OUT_CTRL_OFFSET, 32'h8000, rs); pins(1'b0, 1'b0);
		`CHK({own_hi, own_lo}, 2'b10)
		// Every mode with waveform A high and B low
		wa <= 1'b1;
		for (m = 0; m < 4; m++) begin
			axw(OUT_CTRL_OFFSET, 32'hC000 | (m << 10), rs);
			pins(1'b1, m == 1 ? 1'b1 : 1'b0);
		end
		wb <= 1'b1; pins(1'b1, 1'b1);
		axw(OUT_CTRL_OFFSET, 32'hC400, rs); pins(1'b1, 1'b1);
		`CHK(overlap != 16'h0, 1'b1)
		axw(OUT_CTRL_OFFSET, 32'hC000, rs); pins(1'b1, 1'b0);
		// Push-pull swaps pins at each period start
		axw(OUT_CTRL_OFFSET, 32'hC800, rs); pins(1'b1, 1'b0);
		pstart <= 1'b1;
		@(posedge aclk);
		pstart <= 1'b0; pins(1'b0, 1'b1);
		axw(OUT_CTRL_OFFSET, 32'hF400, rs); pins(1'b0, 1'b0);
		axw(OUT_CTRL_OFFSET, 32'hD400, rs); pins(1'b1, 1'b0);
		// Overrides, then the low pin handed back to the generator
		wa <= 1'b0;
		axw(OUT_CTRL_OFFSET, 32'hC380, rs); pins(1'b1, 1'b0);
		axw(OUT_CTRL_OFFSET, 32'hC340, rs); pins(1'b0, 1'b1);
		axw(OUT_CTRL_OFFSET, 32'hC180, rs); pins(1'b1, 1'b1);
		// Fault levels win over override while fault selection is live
		axw(FAULT_CTRL_OFFSET, 32'h1, rs);
		axw(OUT_CTRL_OFFSET, 32'hC320, rs);
		flt <= 1'b1; pins(1'b1, 1'b0);
		axw(FAULT_CTRL_OFFSET, 32'h2, rs);
		axw(OUT_CTRL_OFFSET, 32'hC310, rs); pins(1'b0, 1'b1);
		flt <= 1'b0;
		axw(FAULT_CTRL_OFFSET, 32'h3, rs); pins(1'b0, 1'b0);
		// Latched response keeps fault levels until the status clear
		axw(FAULT_CTRL_OFFSET, 32'h0, rs);
		flt <= 1'b1; pins(1'b0, 1'b1);
		flt <= 1'b0; pins(1'b0, 1'b1);
		axr(STATUS_OFFSET, rd, rs); `CHK(rd, 32'h0000_000A)
		axw(STATUS_OFFSET, 32'h8, rs); `CHK(rs, RESP_OKAY)
		pins(1'b0, 1'b0);
		axr(STATUS_OFFSET, rd, rs); `CHK(rd, 32'h0000_0000)
		final_report();
	end
endmodule : pwm_output_pin_control_bench
